// File: clid_decoder.sv
// Instruction decoder, address counter and display state behind an APB slave.
`timescale 1ns/1ps
`default_nettype none
`include "clid_defs.svh"
module clid_decoder #(
  parameter int LONG_CYC  = `CLID_CYC(`CLID_T_LONG_NS),
  parameter int SHORT_CYC = `CLID_CYC(`CLID_T_SHORT_NS),
  parameter int DATA_CYC  = `CLID_CYC(`CLID_T_DATA_NS),
  parameter int BLINK_CYC = `CLID_CYC(`CLID_T_BLINK_NS)
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output var  logic [31:0]   prdata,
  output var  logic          pready,
  output var  logic          pslverr,
  output var  logic          busy_indicator,
  output var  logic          display_enable,
  output var  logic          cursor_visible,
  output var  logic [7:0]    cursor_cell,
  output var  clid_pkg::clid_addr_t scroll_offset
);
  import clid_pkg::*;

  // ----------------------------------------
  // Storage and state
  // ----------------------------------------
  logic [7:0]  char_mem [0:127];
  logic [7:0]  glyph_mem [0:63];
  clid_state_e state;
  logic [31:0] timer;
  logic [31:0] blink_cnt;
  logic        blink_phase;
  clid_addr_t  address_counter;
  clid_addr_t  fill_idx;
  logic        glyph_sel;
  logic        step_inc;
  logic        whole_screen_scroll;
  logic        disp_on;
  logic        cur_on;
  logic        flash_on;
  logic        bus_width_select;
  logic        two_row;
  logic        tall_font;
  logic        nib_phase;
  logic [3:0]  nib_hold;
  logic        rd_phase;
  logic        acc;
  logic        bus_wr;
  logic        issue;
  logic        issue_ts;
  logic [7:0]  command_holding;
  logic [7:0]  status_byte;
  logic [7:0]  next_cell;
  logic [31:0] next_rdata;
  logic        next_err;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic clid_addr_t step_addr(clid_addr_t a, logic up, logic glyph, logic rows2);
    clid_addr_t r;
    r = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
    if (glyph) begin
      r[6] = 1'b0;
    end else if (rows2) begin
      if (up && a == `CLID_ROW1_LAST) begin
        r = `CLID_ROW2_FIRST;
      end else if (up && a == `CLID_ROW2_LAST) begin
        r = `CLID_ADDR_ZERO;
      end else if (!up && a == `CLID_ROW2_FIRST) begin
        r = `CLID_ROW1_LAST;
      end else if (!up && a == `CLID_ADDR_ZERO) begin
        r = `CLID_ROW2_LAST;
      end
    end else begin
      if (up && a == `CLID_ONE_LAST) begin
        r = `CLID_ADDR_ZERO;
      end else if (!up && a == `CLID_ADDR_ZERO) begin
        r = `CLID_ONE_LAST;
      end
    end
    return r;
  endfunction

  function automatic clid_addr_t shift_off(clid_addr_t o, logic left, logic rows2);
    clid_addr_t last;
    last = rows2 ? 7'(`CLID_LEN_TWO - 7'h01) : 7'(`CLID_LEN_ONE - 7'h01);
    if (left) begin
      return (o >= last) ? `CLID_ADDR_ZERO : 7'(o + 7'h01);
    end
    return (o == `CLID_ADDR_ZERO || o > last) ? last : 7'(o - 7'h01);
  endfunction

  // ----------------------------------------
  // APB access and byte assembly
  // ----------------------------------------
  // The slave answers one cycle into the access phase, so every access costs one wait state.
  assign acc    = psel && penable && pready;
  assign bus_wr = acc && pwrite && paddr == `CLID_REG_BUS;
  assign status_byte = {busy_indicator, address_counter};

  always_comb begin
    issue           = 1'b0;
    issue_ts        = pwdata[`CLID_TS_BIT];
    command_holding = pwdata[7:0];
    if (bus_wr) begin
      if (bus_width_select) begin
        issue = 1'b1;
      end else if (nib_phase) begin
        command_holding = {nib_hold, pwdata[7:4]};
        issue           = 1'b1;
      end
    end
    // Instructions sent while busy are dropped; the host is expected to poll first.
    if (state != CLID_IDLE) begin
      issue = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nib_phase <= 1'b0;
      nib_hold  <= 4'h0;
    end else if (issue && !issue_ts && command_holding[7:5] == 3'b001) begin
      nib_phase <= 1'b0;
    end else if (bus_wr && !bus_width_select) begin
      nib_phase <= !nib_phase;
      nib_hold  <= pwdata[7:4];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_phase <= 1'b0;
    end else if (acc && !pwrite && paddr == `CLID_REG_STATUS && !bus_width_select) begin
      rd_phase <= !rd_phase;
    end
  end

  always_comb begin
    next_err   = 1'b0;
    next_rdata = 32'h0000_0000;
    if (paddr == `CLID_REG_BUS) begin
      next_rdata = 32'h0000_0000;
    end else if (paddr == `CLID_REG_STATUS) begin
      if (bus_width_select) begin
        next_rdata = {24'h00_0000, status_byte};
      end else if (rd_phase) begin
        next_rdata = {24'h00_0000, status_byte[3:0], 4'h0};
      end else begin
        next_rdata = {24'h00_0000, status_byte[7:4], 4'h0};
      end
    end else if (paddr == `CLID_REG_STATE) begin
      next_rdata = {9'h000, scroll_offset, 4'h0, glyph_sel, tall_font, two_row,
                    bus_width_select, whole_screen_scroll, step_inc, flash_on, cur_on,
                    disp_on, 1'b0, state};
    end else if (paddr == `CLID_REG_CELL) begin
      next_rdata = {24'h00_0000, next_cell};
    end else begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && next_err;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------
  // Sequencer and busy timing
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= CLID_IDLE;
      timer    <= 32'h0000_0000;
      fill_idx <= `CLID_ADDR_ZERO;
    end else begin
      if (timer != 32'h0000_0000) begin
        timer <= timer - 32'h0000_0001;
      end
      case (state)
        CLID_IDLE: begin
          if (issue && issue_ts) begin
            state <= CLID_WAIT;
            timer <= 32'(DATA_CYC);
          end else if (issue && command_holding[7:1] == 7'h00 && command_holding[0]) begin
            state    <= CLID_FILL;
            timer    <= 32'(LONG_CYC);
            fill_idx <= `CLID_ADDR_ZERO;
          end else if (issue && command_holding[7:1] == 7'h01) begin
            state <= CLID_WAIT;
            timer <= 32'(LONG_CYC);
          end else if (issue && command_holding != 8'h00) begin
            state <= CLID_WAIT;
            timer <= 32'(SHORT_CYC);
          end
        end
        CLID_FILL: begin
          fill_idx <= 7'(fill_idx + 7'h01);
          if (fill_idx == `CLID_ADDR_TOP) begin
            state <= CLID_WAIT;
          end
        end
        CLID_WAIT: begin
          if (timer <= 32'h0000_0001) begin
            state <= CLID_IDLE;
          end
        end
        default: begin
          state <= CLID_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_indicator <= 1'b0;
    end else begin
      busy_indicator <= issue || (state != CLID_IDLE && !(state == CLID_WAIT && timer <= 32'h0000_0001));
    end
  end

  // ----------------------------------------
  // Memories
  // ----------------------------------------
  always_ff @(posedge pclk) begin
    if (state == CLID_FILL) begin
      char_mem[fill_idx] <= `CLID_SPACE;
    end else if (issue && issue_ts && !glyph_sel) begin
      char_mem[address_counter] <= command_holding;
    end
  end

  always_ff @(posedge pclk) begin
    if (issue && issue_ts && glyph_sel) begin
      glyph_mem[address_counter[5:0]] <= command_holding;
    end
  end

  // ----------------------------------------
  // Instruction execution
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      address_counter     <= `CLID_ADDR_ZERO;
      scroll_offset       <= `CLID_ADDR_ZERO;
      glyph_sel           <= 1'b0;
      step_inc            <= 1'b1;
      whole_screen_scroll <= 1'b0;
      disp_on             <= 1'b0;
      cur_on              <= 1'b0;
      flash_on            <= 1'b0;
      bus_width_select    <= 1'b1;
      two_row             <= 1'b0;
      tall_font           <= 1'b0;
    end else if (issue && issue_ts) begin
      address_counter <= step_addr(address_counter, step_inc, glyph_sel, two_row);
      if (whole_screen_scroll && !glyph_sel) begin
        scroll_offset <= shift_off(scroll_offset, step_inc, two_row);
      end
    end else if (issue) begin
      if (command_holding[7]) begin
        address_counter <= command_holding[6:0];
        glyph_sel       <= 1'b0;
      end else if (command_holding[6]) begin
        address_counter <= {1'b0, command_holding[5:0]};
        glyph_sel       <= 1'b1;
      end else if (command_holding[5]) begin
        bus_width_select <= command_holding[`CLID_FS_WIDTH];
        two_row          <= command_holding[`CLID_FS_ROWS];
        tall_font        <= command_holding[`CLID_FS_FONT];
      end else if (command_holding[4]) begin
        if (command_holding[`CLID_SH_SC]) begin
          scroll_offset <= shift_off(scroll_offset, !command_holding[`CLID_SH_RL], two_row);
        end else begin
          address_counter <= step_addr(address_counter, command_holding[`CLID_SH_RL],
                                       glyph_sel, two_row);
        end
      end else if (command_holding[3]) begin
        disp_on  <= command_holding[`CLID_DC_DISP];
        cur_on   <= command_holding[`CLID_DC_CUR];
        flash_on <= command_holding[`CLID_DC_FLASH];
      end else if (command_holding[2]) begin
        step_inc            <= command_holding[`CLID_EM_DIR];
        whole_screen_scroll <= command_holding[`CLID_EM_SCROLL];
      end else if (command_holding[1]) begin
        address_counter <= `CLID_ADDR_ZERO;
        scroll_offset   <= `CLID_ADDR_ZERO;
        glyph_sel       <= 1'b0;
      end else if (command_holding[0]) begin
        address_counter <= `CLID_ADDR_ZERO;
        scroll_offset   <= `CLID_ADDR_ZERO;
        glyph_sel       <= 1'b0;
        step_inc        <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Cursor flash and display outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt   <= 32'h0000_0000;
      blink_phase <= 1'b0;
    end else if (!flash_on) begin
      blink_cnt   <= 32'h0000_0000;
      blink_phase <= 1'b0;
    end else if (blink_cnt >= 32'(BLINK_CYC - 1)) begin
      blink_cnt   <= 32'h0000_0000;
      blink_phase <= !blink_phase;
    end else begin
      blink_cnt <= blink_cnt + 32'h0000_0001;
    end
  end

  assign next_cell = (flash_on && blink_phase) ? `CLID_ALL_ONES : char_mem[address_counter];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      display_enable <= 1'b0;
      cursor_visible <= 1'b0;
      cursor_cell    <= 8'h00;
    end else begin
      display_enable <= disp_on;
      cursor_visible <= disp_on && cur_on;
      cursor_cell    <= next_cell;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_status_busy_bit: assert property (
    psel && penable && !pready && !pwrite && paddr == `CLID_REG_STATUS && bus_width_select
    |=> prdata[`CLID_BUSY_BIT] == $past(busy_indicator) && prdata[6:0] == $past(address_counter))
    else $error("status read does not show busy and counter");
  a_busy_after_cmd: assert property (
    issue && (issue_ts || command_holding != 8'h00) |=> busy_indicator [*4])
    else $error("busy not held after an instruction");
  a_clear_homes: assert property (
    issue && !issue_ts && command_holding == 8'h01
    |=> address_counter == `CLID_ADDR_ZERO && step_inc && state == CLID_FILL)
    else $error("clear did not home and fill");
  a_home_unshift: assert property (
    issue && !issue_ts && command_holding[7:1] == 7'h01
    |=> address_counter == `CLID_ADDR_ZERO && scroll_offset == `CLID_ADDR_ZERO)
    else $error("home did not reset counter and shift");
  a_char_addr_set: assert property (
    issue && !issue_ts && command_holding[7]
    |=> address_counter == $past(command_holding[6:0]) && !glyph_sel)
    else $error("character address set failed");
  a_glyph_addr_set: assert property (
    issue && !issue_ts && command_holding[7:6] == 2'b01
    |=> address_counter == {1'b0, $past(command_holding[5:0])} && glyph_sel)
    else $error("glyph address set failed");
  a_row_carry: assert property (
    issue && issue_ts && two_row && step_inc && !glyph_sel && address_counter == `CLID_ROW1_LAST
    |=> address_counter == `CLID_ROW2_FIRST)
    else $error("cursor did not carry into second row");
  a_shift_keeps_ac: assert property (
    issue && !issue_ts && command_holding[7:4] == 4'h1 && command_holding[`CLID_SH_SC]
    |=> $stable(address_counter))
    else $error("screen shift changed the counter");
  a_write_steps_dec: assert property (
    issue && issue_ts && !step_inc && !glyph_sel && address_counter == 7'h05
    |=> address_counter == 7'h04)
    else $error("decrement step wrong");
  a_width_select: assert property (
    issue && !issue_ts && command_holding[7:5] == 3'b001
    |=> bus_width_select == $past(command_holding[`CLID_FS_WIDTH]) && !nib_phase)
    else $error("bus width not taken");
endmodule
`default_nettype wire

// File: clid_defs.svh
// Constants for the character display instruction decoder.
//
// What this block does
// - Two rows use 00h-27h and 40h-67h; one row uses 00h-4Fh.
// - Busy reads as 1 on bit 7 while an operation runs.
// - Clear fills memory with spaces, zeroes counter, homes cursor, sets increment.
// - Home zeroes counter and undoes shift, memory kept.
// - Step direction 1 moves cursor right and increments counter after access.
// - Step direction 0 moves cursor left after each access.
// - Scroll bit shifts screen on character writes only, direction from step bit.
// - Visibility bit blanks screen keeping memory; cursor bit shows or hides cursor.
// - Flash bit alternates cursor cell between all ones and stored character.
// - Cursor shift moves left with decrement or right with increment.
// - Screen shift moves all left or right, cursor follows display.
// - Screen shift hits all rows and leaves counter unchanged.
// - Two rows: cursor passes from position 40 into second row.
// - Width bit picks 8-bit or 4-bit transfers; 4-bit moves two parts.
// - Row bit picks one or two rows; height bit picks 5x7 or 5x10.
// - Glyph address set loads 6 bits and targets glyph memory.
// - Character address set loads 7 bits and targets character memory.
// - Status read gives busy on bit 7 and counter below.
// - Data write stores byte in memory chosen by last address set.
// - After each data write the counter steps by one.
// - Function set is 001, width, rows, height, two ignored bits.
// - Status read uses select low, read direction, no execution time.
// - In 4-bit mode upper nibble crosses first, then lower.
`ifndef CLID_DEFS_SVH
`define CLID_DEFS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define CLID_REG_BUS     8'h00
`define CLID_REG_STATUS  8'h04
`define CLID_REG_STATE   8'h08
`define CLID_REG_CELL    8'h0C
`define CLID_TS_BIT      8
// ----------------------------------------
// Instruction fields
// ----------------------------------------
`define CLID_BUSY_BIT    7
`define CLID_FS_WIDTH    4
`define CLID_FS_ROWS     3
`define CLID_FS_FONT     2
`define CLID_DC_DISP     2
`define CLID_DC_CUR      1
`define CLID_DC_FLASH    0
`define CLID_EM_DIR      1
`define CLID_EM_SCROLL   0
`define CLID_SH_SC       3
`define CLID_SH_RL       2
// ----------------------------------------
// Addresses and codes
// ----------------------------------------
`define CLID_ADDR_ZERO   7'h00
`define CLID_ROW1_LAST   7'h27
`define CLID_ROW2_FIRST  7'h40
`define CLID_ROW2_LAST   7'h67
`define CLID_ONE_LAST    7'h4F
`define CLID_ADDR_TOP    7'h7F
`define CLID_GLYPH_TOP   6'h3F
`define CLID_LEN_TWO     7'h28
`define CLID_LEN_ONE     7'h50
`define CLID_SPACE       8'h20
`define CLID_ALL_ONES    8'hFF
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLID_CLK_NS      8
`define CLID_T_LONG_NS   1530000
`define CLID_T_SHORT_NS  39000
`define CLID_T_DATA_NS   43000
`define CLID_T_BLINK_NS  400000000
`define CLID_CYC(t)      (((t) + `CLID_CLK_NS - 1) / `CLID_CLK_NS)
`endif

// File: clid_pkg.sv
// Types shared by the character display instruction decoder.
`default_nettype none
package clid_pkg;
  typedef enum logic [1:0] {
    CLID_IDLE = 2'b00,
    CLID_FILL = 2'b01,
    CLID_WAIT = 2'b10
  } clid_state_e;
  typedef logic [6:0] clid_addr_t;
endpackage
`default_nettype wire

// File: clid_host.sv
// Host processor model that drives the instruction decoder over APB.
`timescale 1ns/1ps
`default_nettype none
module clid_host #(
  parameter int HALF_OSC = 2
) (
  input  wire logic        pclk,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic nib4;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    nib4 = 1'b0;
  end

  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // In nibble mode the upper half travels first on bits 7:4.
  task automatic put(input logic rs, input logic [7:0] b);
    logic [31:0] q;
    logic        e;
    if (nib4) begin
      xfer(1'b1, 8'h00, {23'h0, rs, b[7:4], 4'h0}, q, e);
      xfer(1'b1, 8'h00, {23'h0, rs, b[3:0], 4'h0}, q, e);
    end else begin
      xfer(1'b1, 8'h00, {23'h0, rs, b}, q, e);
    end
  endtask

  task automatic status(output logic [7:0] s);
    logic [31:0] q1;
    logic [31:0] q2;
    logic        e;
    xfer(1'b0, 8'h04, 32'h0, q1, e);
    s = q1[7:0];
    if (nib4) begin
      xfer(1'b0, 8'h04, 32'h0, q2, e);
      s = {q1[7:4], q2[7:4]};
    end
  endtask

  // Polling rather than counting keeps a slow decoder from being overrun.
  task automatic idle();
    logic [7:0] s;
    s = 8'h80;
    while (s[7]) status(s);
    repeat (HALF_OSC) @(posedge pclk);
  endtask

  task automatic send(input logic rs, input logic [7:0] b);
    put(rs, b);
    idle();
  endtask
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking testbench for the character display instruction decoder.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import clid_pkg::*;
  logic        pclk;
  logic        presetn;
  wire         psel;
  wire         penable;
  wire         pwrite;
  wire  [7:0]  paddr;
  wire  [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         busy_indicator;
  wire         display_enable;
  wire         cursor_visible;
  wire  [7:0]  cursor_cell;
  clid_addr_t  scroll_offset;
  int          num_errors;
  int          checks_done;

  clid_decoder #(.LONG_CYC(200), .SHORT_CYC(8), .DATA_CYC(8), .BLINK_CYC(16)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy_indicator(busy_indicator),
    .display_enable(display_enable), .cursor_visible(cursor_visible),
    .cursor_cell(cursor_cell), .scroll_offset(scroll_offset));

  clid_host host (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  always #4 pclk = ~pclk;

  // ----------------------------------------
  // Compare helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    host.xfer(1'b0, a, 32'h0, q, e);
    chk(q & m, exp);
  endtask

  task automatic chk_st(input logic [31:0] m, input logic [31:0] exp);
    logic [7:0] s;
    host.status(s);
    chk({24'h0, s} & m, exp);
  endtask

  task automatic cmd(input logic [7:0] b);
    host.send(1'b0, b);
  endtask

  task automatic dat(input logic [7:0] b);
    host.send(1'b1, b);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk_reg(8'h08, 32'h007F_0FFB, 32'h0000_0140);
    chk({31'h0, display_enable}, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_clear();
    cmd(8'h04);
    cmd(8'hC5);
    dat(8'h33);
    host.put(1'b0, 8'h01);
    chk_st(32'h80, 32'h80);
    chk({31'h0, busy_indicator}, 32'h1);
    host.idle();
    chk({31'h0, busy_indicator}, 32'h0);
    chk_st(32'hFF, 32'h00);
    chk_reg(8'h0C, 32'hFF, 32'h20);
    chk_reg(8'h08, 32'h40, 32'h40);
    cmd(8'hC5);
    chk_reg(8'h0C, 32'hFF, 32'h20);
    $display("test clear done");
  endtask

  task automatic t_rows();
    cmd(8'h3C);
    chk_reg(8'h08, 32'h700, 32'h700);
    cmd(8'h38);
    chk_reg(8'h08, 32'h700, 32'h300);
    cmd(8'hA7);
    chk_st(32'hFF, 32'h27);
    dat(8'h41);
    chk_st(32'hFF, 32'h40);
    cmd(8'hA7);
    chk_reg(8'h0C, 32'hFF, 32'h41);
    cmd(8'hE7);
    dat(8'h00);
    chk_st(32'hFF, 32'h00);
    $display("test rows done");
  endtask

  task automatic t_dir();
    cmd(8'h04);
    cmd(8'h85);
    dat(8'h11);
    chk_st(32'hFF, 32'h04);
    cmd(8'h14);
    chk_st(32'hFF, 32'h05);
    cmd(8'h10);
    chk_st(32'hFF, 32'h04);
    $display("test direction done");
  endtask

  task automatic t_shift();
    cmd(8'h18);
    chk({25'h0, scroll_offset}, 32'h1);
    chk_st(32'hFF, 32'h04);
    cmd(8'h1C);
    chk({25'h0, scroll_offset}, 32'h0);
    cmd(8'h07);
    dat(8'h22);
    chk({25'h0, scroll_offset}, 32'h1);
    cmd(8'h45);
    chk_reg(8'h08, 32'h800, 32'h800);
    dat(8'h1F);
    chk({25'h0, scroll_offset}, 32'h1);
    chk_st(32'hFF, 32'h06);
    cmd(8'h02);
    chk({25'h0, scroll_offset}, 32'h0);
    chk_st(32'hFF, 32'h00);
    cmd(8'h06);
    $display("test shift done");
  endtask

  task automatic t_disp();
    int on;
    int off;
    cmd(8'h0E);
    chk({30'h0, display_enable, cursor_visible}, 32'h3);
    cmd(8'h0B);
    chk({30'h0, display_enable, cursor_visible}, 32'h0);
    cmd(8'h0F);
    on = 0;
    off = 0;
    repeat (100) begin
      @(posedge pclk);
      if (cursor_cell === 8'hFF) on++;
      if (cursor_cell === 8'h20) off++;
    end
    chk({30'h0, on != 0, off != 0}, 32'h3);
    cmd(8'h0C);
    on = 0;
    repeat (40) begin
      @(posedge pclk);
      if (cursor_cell === 8'hFF) on++;
    end
    chk(on, 32'h0);
    $display("test display done");
  endtask

  task automatic t_err();
    logic [31:0] q;
    logic        e;
    host.xfer(1'b0, 8'h10, 32'h0, q, e);
    chk({e, q[30:0]}, 32'h8000_0000);
    $display("test unmapped done");
  endtask

  task automatic t_nib();
    // The width changes as soon as this command lands, so polling must already use nibbles.
    host.put(1'b0, 8'h28);
    host.nib4 = 1'b1;
    host.idle();
    chk_reg(8'h08, 32'h300, 32'h200);
    cmd(8'h85);
    chk_st(32'hFF, 32'h05);
    dat(8'h5A);
    cmd(8'h85);
    chk_reg(8'h0C, 32'hFF, 32'h5A);
    $display("test nibble done");
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    num_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_clear();
    t_rows();
    t_dir();
    t_shift();
    t_disp();
    t_err();
    t_nib();
    results();
  end

  // The tests need about 1300 cycles; this margin only catches a hang.
  initial begin
    repeat (50000) @(posedge pclk);
    num_errors++;
    results();
  end
endmodule
`default_nettype wire
